// ---- inc/adcc_regs.vh ----
// How it works
// RL1 - convert the source chosen by input select
// RL2 - start on software start bit or trigger
// RL3 - free-run restarts after each conversion end
// RL4 - each result overwrites the result register
// RL5 - result ready flag set on new result
// RL6 - overrun flag when unread result replaced
// RL7 - software reads each result promptly
// RL8 - enable set writes one, zero leaves unchanged
// RL9 - conversion paced by prescaled converter clock
// RL10 - software initializes before any conversion
// RL11 - protected registers written only while disabled
// RL12 - soft reset clears all but debug, disables
// RL13 - irq while enabled flag set, write-one clears
`ifndef ADCC_REGS_VH
`define ADCC_REGS_VH
// register byte offsets (paddr[7:0])
`define ADCC_OFF_CTL_A 8'h00
`define ADCC_OFF_CTL_B 8'h04
`define ADCC_OFF_REF 8'h08
`define ADCC_OFF_EVT 8'h0C
`define ADCC_OFF_CAL 8'h10
`define ADCC_OFF_INSEL 8'h14
`define ADCC_OFF_SOFT_TRIG 8'h18
`define ADCC_OFF_INTENCLR 8'h1C
`define ADCC_OFF_IEN_SET 8'h20
`define ADCC_OFF_IFLAG 8'h24
`define ADCC_OFF_RESULT 8'h28
`define ADCC_OFF_DBG 8'h2C
`define ADCC_OFF_STATUS 8'h30
// field positions
`define ADCC_CTL_A_SOFT_RST 0
`define ADCC_CTL_A_ENABLE 1
`define ADCC_CTL_A_FREERUN 2
`define ADCC_TRIG_START 1
`define ADCC_EV_STARTEI 0
`define ADCC_EV_RISING 1
`define ADCC_INT_READY 0
`define ADCC_INT_OVERRUN 1
`define ADCC_DBG_RUN 0
`define ADCC_STATUS_BUSY 0
// reset values
`define ADCC_CTL_A_RST 2'h0
`define ADCC_CTL_B_RST 3'h0
`define ADCC_REF_RST 4'h0
`define ADCC_EV_RST 2'h0
`define ADCC_CAL_RST 16'h0000
`define ADCC_INSEL_RST 5'h00
`define ADCC_INT_RST 2'h0
`define ADCC_RESULT_RST 12'h000
`define ADCC_DBG_RST 1'h0
// prescaled ticks per conversion
`define ADCC_CONV_TICKS 4'hD
`endif

// ---- core/adcc_sync2.v ----
`timescale 1ns/1ps
`default_nettype none
// two flop synchroniser for levels from outside the clock domain
module adcc_sync2 #(
    parameter W = 1
) (
    input wire clk,
    input wire reset,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_reg; // first stage, read by q only

    // both stages clear on reset
    always @(posedge clk) begin
        if (reset) begin
            meta_reg <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule // adcc_sync2
`default_nettype wire

// ---- core/adcc_presc.v ----
`timescale 1ns/1ps
`default_nettype none
// prescaler: one tick every 2^(sel+1) clocks while run is high
module adcc_presc (
    input wire clk,
    input wire reset,
    input wire run,
    input wire [2:0] sel,
    output wire tick
);
    reg [7:0] cnt_reg; // free count, restarted whenever run drops
    wire [7:0] mask; // low ones select the division

    assign mask = 8'hFF >> (3'h7 - sel);
    // tick when all masked bits are one
    assign tick = run & ((cnt_reg & mask) == mask); // RL9

    // count only while a conversion needs the clock
    always @(posedge clk) begin
        if (reset || !run) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
endmodule // adcc_presc
`default_nettype wire

// ---- core/adcc_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "adcc_regs.vh"
// converter control: apb registers, trigger, sequencer, flags
module adcc_top (
    input wire clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg irq,
    input wire debug_halt,
    input wire trig_pin,
    input wire [11:0] fe_data,
    output reg [4:0] fe_select,
    output reg [3:0] fe_ref,
    output reg [15:0] fe_cal,
    output reg fe_sample
);
    // sequencer states
    localparam ST_IDLE = 2'h0;
    localparam ST_CONV = 2'h1;
    localparam ST_DONE = 2'h2;

    reg [1:0] control_a_register_reg; // [0] enable, [1] free run
    reg [2:0] control_b_register_reg; // prescaler select
    reg [1:0] ev_reg; // trigger enable and edge
    reg dbg_reg; // run while halted, survives soft reset
    reg [1:0] inten_reg; // interrupt enables
    reg [1:0] flag_reg; // sticky interrupt flags
    reg [11:0] result_reg; // last conversion result
    reg unread_reg; // result not yet read
    reg start_reg; // start request waiting for sequencer
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [3:0] tick_reg; // prescaled ticks in this conversion
    reg trig_prev_reg; // last synced trigger level
    reg [31:0] rdata_next;
    reg rdok_next; // address is mapped

    wire trig_s; // synced trigger pin
    wire [11:0] data_s; // synced converter output
    wire tick;
    wire enable;
    wire freerun;
    wire acc; // apb access completes this edge
    wire wr;
    wire rd;
    wire soft_rst; // soft reset write
    wire rst_all; // hard or soft reset
    wire halted;
    wire trig_evt;
    wire start_set;
    wire conv_end;
    wire [1:0] flag_set;
    wire [1:0] flag_clr;

    assign enable = control_a_register_reg[0];
    assign freerun = control_a_register_reg[1];
    assign acc = psel & penable & pready;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;
    // soft reset acts on the completing write edge
    assign soft_rst = wr && (paddr == `ADCC_OFF_CTL_A) &&
                   pwdata[`ADCC_CTL_A_SOFT_RST]; // RL12
    assign rst_all = reset | soft_rst; // RL12
    // a debug halt freezes conversions unless told to run
    assign halted = debug_halt & ~dbg_reg;

    // trigger pin and converter data come from another domain
    adcc_sync2 #(.W(1)) u_trig_sync (
        .clk(clk),
        .reset(reset),
        .d(trig_pin),
        .q(trig_s)
    );
    adcc_sync2 #(.W(12)) u_data_sync (
        .clk(clk),
        .reset(reset),
        .d(fe_data),
        .q(data_s)
    );

    // prescaler only runs during a conversion
    adcc_presc u_presc (
        .clk(clk),
        .reset(rst_all),
        .run(state_reg == ST_CONV && !halted),
        .sel(control_b_register_reg),
        .tick(tick)
    );

    // trigger fires on the chosen edge of the synced pin
    assign trig_evt = ev_reg[`ADCC_EV_STARTEI] &&
        (ev_reg[`ADCC_EV_RISING] ? (trig_s & ~trig_prev_reg) :
                                   (~trig_s & trig_prev_reg));
    // software start bit or automatic trigger
    assign start_set = enable && (trig_evt || (wr &&
        (paddr == `ADCC_OFF_SOFT_TRIG) &&
        pwdata[`ADCC_TRIG_START])); // RL2
    assign conv_end = (state_reg == ST_DONE);

    // flag events and write-one clears
    assign flag_set = {conv_end & unread_reg, conv_end}; // RL5 RL6
    assign flag_clr = (wr && paddr == `ADCC_OFF_IFLAG) ?
                      pwdata[1:0] : 2'h0; // RL13

    // control registers and their write rules
    always @(posedge clk) begin
        if (rst_all) begin
            control_a_register_reg <= `ADCC_CTL_A_RST; // RL12
            control_b_register_reg <= `ADCC_CTL_B_RST;
            fe_ref <= `ADCC_REF_RST;
            ev_reg <= `ADCC_EV_RST;
            fe_cal <= `ADCC_CAL_RST;
            fe_select <= `ADCC_INSEL_RST;
            inten_reg <= `ADCC_INT_RST;
        end else if (wr) begin
            case (paddr)
                `ADCC_OFF_CTL_A: begin
                    control_a_register_reg <= {pwdata[`ADCC_CTL_A_FREERUN],
                                  pwdata[`ADCC_CTL_A_ENABLE]};
                end
                // protected registers ignore writes when enabled
                `ADCC_OFF_CTL_B: begin
                    if (!enable) begin
                        control_b_register_reg <= pwdata[2:0]; // RL11
                    end
                end
                `ADCC_OFF_REF: begin
                    if (!enable) begin
                        fe_ref <= pwdata[3:0]; // RL11
                    end
                end
                `ADCC_OFF_EVT: begin
                    if (!enable) begin
                        ev_reg <= pwdata[1:0]; // RL11
                    end
                end
                `ADCC_OFF_CAL: begin
                    if (!enable) begin
                        fe_cal <= pwdata[15:0]; // RL11
                    end
                end
                // channel select goes straight to the front end
                `ADCC_OFF_INSEL: begin
                    fe_select <= pwdata[4:0]; // RL1
                end
                // ones set, zeros leave the enable alone
                `ADCC_OFF_IEN_SET: begin
                    inten_reg <= inten_reg | pwdata[1:0]; // RL8
                end
                `ADCC_OFF_INTENCLR: begin
                    inten_reg <= inten_reg & ~pwdata[1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // debug control is kept over a soft reset
    always @(posedge clk) begin
        if (reset) begin
            dbg_reg <= `ADCC_DBG_RST;
        end else if (wr && paddr == `ADCC_OFF_DBG) begin
            dbg_reg <= pwdata[`ADCC_DBG_RUN]; // RL12
        end
    end

    // sequencer next state
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start_reg && enable && !halted) begin
                    state_next = ST_CONV;
                end
            end
            ST_CONV: begin
                // fixed tick count sets the conversion time
                if (tick && tick_reg == `ADCC_CONV_TICKS - 4'h1) begin
                    state_next = ST_DONE; // RL9
                end
            end
            ST_DONE: begin
                // free run chains straight into the next one
                if (freerun && enable) begin
                    state_next = ST_CONV; // RL3
                end else begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // a disable aborts any conversion in flight
        if (!enable) begin
            state_next = ST_IDLE;
        end
    end

    // sequencer state, tick count and sample strobe
    always @(posedge clk) begin
        if (rst_all) begin
            state_reg <= ST_IDLE;
            tick_reg <= 4'h0;
            fe_sample <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_next != ST_CONV || state_reg != ST_CONV) begin
                tick_reg <= 4'h0;
            end else if (tick) begin
                tick_reg <= tick_reg + 4'h1;
            end
            fe_sample <= (state_next == ST_CONV); // RL1
        end
    end

    // start request held until the sequencer takes it
    always @(posedge clk) begin
        if (rst_all) begin
            start_reg <= 1'b0;
        end else if (start_set) begin
            start_reg <= 1'b1; // RL2
        end else if (state_reg == ST_IDLE && state_next == ST_CONV) begin
            start_reg <= 1'b0;
        end else if (!enable) begin
            start_reg <= 1'b0;
        end
    end

    // trigger edge history
    always @(posedge clk) begin
        if (rst_all) begin
            trig_prev_reg <= 1'b0;
        end else begin
            trig_prev_reg <= trig_s;
        end
    end

    // result capture; a new result beats a read in the same cycle
    always @(posedge clk) begin
        if (rst_all) begin
            result_reg <= `ADCC_RESULT_RST;
            unread_reg <= 1'b0;
        end else if (conv_end) begin
            result_reg <= data_s; // RL4
            unread_reg <= 1'b1;
        end else if (rd && paddr == `ADCC_OFF_RESULT) begin
            unread_reg <= 1'b0;
        end
    end

    // sticky flags: set wins over a same-cycle clear
    always @(posedge clk) begin
        if (rst_all) begin
            flag_reg <= `ADCC_INT_RST;
        end else begin
            flag_reg <= (flag_reg & ~flag_clr) | flag_set; // RL5 RL6 RL13
        end
    end

    // one level interrupt for all enabled flags
    always @(posedge clk) begin
        if (rst_all) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flag_reg & inten_reg); // RL13
        end
    end

    // read data mux; unmapped offsets read zero with an error
    always @* begin
        rdata_next = 32'h00000000;
        rdok_next = 1'b1;
        case (paddr)
            `ADCC_OFF_CTL_A: begin
                rdata_next[`ADCC_CTL_A_ENABLE] = enable;
                rdata_next[`ADCC_CTL_A_FREERUN] = freerun;
            end
            `ADCC_OFF_CTL_B: begin
                rdata_next[2:0] = control_b_register_reg;
            end
            `ADCC_OFF_REF: begin
                rdata_next[3:0] = fe_ref;
            end
            `ADCC_OFF_EVT: begin
                rdata_next[1:0] = ev_reg;
            end
            `ADCC_OFF_CAL: begin
                rdata_next[15:0] = fe_cal;
            end
            `ADCC_OFF_INSEL: begin
                rdata_next[4:0] = fe_select;
            end
            // start bit is write only
            `ADCC_OFF_SOFT_TRIG: begin
                rdata_next = 32'h00000000;
            end
            `ADCC_OFF_INTENCLR: begin
                rdata_next[1:0] = inten_reg;
            end
            `ADCC_OFF_IEN_SET: begin
                rdata_next[1:0] = inten_reg;
            end
            `ADCC_OFF_IFLAG: begin
                rdata_next[1:0] = flag_reg;
            end
            `ADCC_OFF_RESULT: begin
                rdata_next[11:0] = result_reg;
            end
            `ADCC_OFF_DBG: begin
                rdata_next[`ADCC_DBG_RUN] = dbg_reg;
            end
            `ADCC_OFF_STATUS: begin
                rdata_next[`ADCC_STATUS_BUSY] = (state_reg != ST_IDLE);
            end
            default: begin
                rdok_next = 1'b0;
            end
        endcase
    end

    // apb answer: one wait state, pready for a single cycle
    always @(posedge clk) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~rdok_next;
            if (psel && penable && !pready && !pwrite) begin
                prdata <= rdata_next;
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end
endmodule // adcc_top
`default_nettype wire

// ---- verif/adcc_fe_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// analog front end stand-in: presents a level per selected channel
module adcc_fe_model (
    input wire logic [4:0] fe_select,
    output logic [11:0] fe_data
);
    // channel folded into a fixed pattern so each input reads apart
    assign fe_data = 12'hA50 ^ {7'h00, fe_select};
endmodule // adcc_fe_model
`default_nettype wire

// ---- verif/adcc_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
// port watcher; shadows enables from completed apb writes
module adcc_chk (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic [4:0] fe_select,
    input wire logic [3:0] fe_ref,
    input wire logic [15:0] fe_cal,
    input wire logic fe_sample
);
    // write completes only at the edge that samples pready
    wire wr = psel && penable && pready && pwrite;
    wire srst = wr && paddr == 8'h00 && pwdata[0];
    reg en_reg;
    reg [1:0] ien_reg;
    // protected writes count only while disabled
    wire ref_ok = (wr && paddr == 8'h08 && !en_reg) || srst;
    wire cal_ok = (wr && paddr == 8'h10 && !en_reg) || srst;
    // shadow of enable bit and interrupt enables
    always @(posedge clk) begin
        if (reset || srst) begin
            en_reg <= 1'b0;
            ien_reg <= 2'h0;
        end else if (wr) begin
            if (paddr == 8'h00)
                en_reg <= pwdata[1];
            if (paddr == 8'h20)
                ien_reg <= ien_reg | pwdata[1:0];
            if (paddr == 8'h1C)
                ien_reg <= ien_reg & ~pwdata[1:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sel_write_a: assert property (
        $changed(fe_select) |-> $past(wr) || $past(wr, 2))
        else $error("input select moved without a write");
    ref_guard_a: assert property (
        $changed(fe_ref) |-> $past(ref_ok) || $past(ref_ok, 2))
        else $error("reference changed while enabled");
    cal_guard_a: assert property (
        $changed(fe_cal) |-> $past(cal_ok) || $past(cal_ok, 2))
        else $error("calibration changed while enabled");
    start_gate_a: assert property (
        !en_reg && !$past(en_reg) && !$past(en_reg, 2) |-> !fe_sample)
        else $error("conversion while disabled");
    irq_mask_a: assert property (
        ien_reg == 2'h0 && $past(ien_reg) == 2'h0 |-> !irq)
        else $error("interrupt with no source enabled");
    soft_reset_a: assert property (
        srst |-> ##[1:2] (fe_ref == 4'h0 && fe_cal == 16'h0000
        && fe_select == 5'h00 && !fe_sample))
        else $error("soft reset left state behind");
    done_irq_a: assert property (
        $fell(fe_sample) && en_reg && $past(en_reg) && ien_reg[0]
        |-> ##[1:4] irq)
        else $error("no interrupt after result");
    sample_len_a: assert property (
        $rose(fe_sample) |-> fe_sample [*8])
        else $error("conversion too short");
    cover property (srst);
    cover property ($rose(irq));
    cover property (pready && pslverr);
endmodule // adcc_chk
bind adcc_top adcc_chk u_adcc_chk (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .fe_select(fe_select),
    .fe_ref(fe_ref), .fe_cal(fe_cal), .fe_sample(fe_sample));
`default_nettype wire

// ---- verif/adc_conversion_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic trig_pin = 1'b0;
    logic debug_halt = 1'b0; // halt path left idle
    wire logic pready, pslverr, irq, fe_sample;
    wire logic [31:0] prdata;
    wire logic [11:0] fe_data;
    wire logic [4:0] fe_select;
    wire logic [3:0] fe_ref;
    wire logic [15:0] fe_cal;
    logic [31:0] rd;
    logic err;
    int error_cnt = 0;
    int comparisons = 0;
    int n;
    always #12.5 clk = ~clk;
    adcc_top u_adcc_top (.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .debug_halt(debug_halt),
        .trig_pin(trig_pin), .fe_data(fe_data), .fe_select(fe_select),
        .fe_ref(fe_ref), .fe_cal(fe_cal), .fe_sample(fe_sample));
    adcc_fe_model u_adcc_fe_model (.fe_select(fe_select),
        .fe_data(fe_data));
    task chk(input logic [31:0] s, input logic [31:0] e, input string nm);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    // one apb transfer; answer taken at the edge that sees pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rr(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(rd, e, nm);
    endtask
    // waits out one conversion, counting its length, then settles
    task conv;
        n = 0;
        while (fe_sample !== 1'b1) @(posedge clk);
        while (fe_sample === 1'b1) begin
            @(posedge clk);
            n++;
        end
        repeat (4) @(posedge clk);
    endtask
    // thirteen prescaled ticks; a few cycles of slack for the pipeline
    task clen(input int s);
        chk(n >= 13 * 2 ** (s + 1) - 3 && n <= 13 * 2 ** (s + 1) + 4,
            1, "conversion length");
    endtask
    function logic [31:0] fx(input logic [4:0] s);
        fx = {20'h0, 12'hA50 ^ {7'h00, s}};
    endfunction
    task wait_n(input int k);
        repeat (k) @(posedge clk);
    endtask
    task t_reset;
        chk(fe_ref, 0, "fe_ref");
        rr(8'h00, 0, "control a");
        rr(8'h24, 0, "flags");
        rr(8'h28, 0, "result");
        apb(1'b0, 8'h40, 32'h0);
        chk(err, 1, "unmapped error");
        chk(rd, 0, "unmapped data");
        $display("t_reset done");
    endtask
    task t_protect;
        wr(8'h08, 5);
        wr(8'h10, 32'h1234);
        wr(8'h14, 3);
        wr(8'h00, 2);
        wr(8'h08, 32'hA);
        wr(8'h10, 0);
        rr(8'h08, 5, "reference kept");
        chk(fe_cal, 16'h1234, "calibration kept");
        $display("t_protect done");
    endtask
    task t_conv;
        wr(8'h20, 1);
        wr(8'h18, 2);
        conv;
        clen(0);
        chk(fe_sample, 0, "single shot");
        chk(irq, 1, "irq");
        rr(8'h24, 1, "result ready");
        rr(8'h28, fx(3), "result");
        wr(8'h24, 1);
        wait_n(2);
        chk(irq, 0, "irq cleared");
        wr(8'h00, 0);
        wr(8'h04, 1);
        wr(8'h14, 7);
        wr(8'h00, 2);
        wr(8'h18, 2);
        conv;
        clen(1);
        rr(8'h24, 1, "no overrun");
        rr(8'h28, fx(7), "result replaced");
        $display("t_conv done");
    endtask
    task t_ovr;
        wr(8'h18, 2);
        conv;
        wr(8'h18, 2);
        conv;
        rr(8'h24, 3, "overrun");
        rr(8'h28, fx(7), "result");
        wr(8'h24, 3);
        rr(8'h24, 0, "flags cleared");
        $display("t_ovr done");
    endtask
    task t_ien;
        wr(8'h20, 0);
        rr(8'h1C, 1, "enable kept");
        wr(8'h20, 2);
        rr(8'h1C, 3, "enable set");
        wr(8'h1C, 3);
        wr(8'h18, 2);
        conv;
        chk(irq, 0, "masked irq");
        rr(8'h28, fx(7), "result");
        wr(8'h20, 1);
        wait_n(2);
        chk(irq, 1, "unmasked irq");
        wr(8'h24, 3);
        wait_n(2);
        chk(irq, 0, "irq cleared");
        $display("t_ien done");
    endtask
    task t_trig;
        wr(8'h00, 0);
        wr(8'h0C, 3);
        wr(8'h00, 2);
        trig_pin <= 1'b1;
        conv;
        rr(8'h24, 1, "trigger result");
        rr(8'h28, fx(7), "result");
        trig_pin <= 1'b0;
        wait_n(8);
        chk(fe_sample, 0, "falling edge ignored");
        // falling edge mode: a rise must not start, the fall must
        wr(8'h00, 32'h0);
        wr(8'h0C, 32'h1);
        wr(8'h00, 32'h2);
        trig_pin <= 1'b1;
        wait_n(8);
        chk(fe_sample, 0, "rising edge ignored");
        trig_pin <= 1'b0;
        conv;
        rr(8'h28, fx(7), "falling trigger result");
        $display("t_trig done");
    endtask
    task t_free;
        wr(8'h00, 6);
        wr(8'h18, 2);
        conv;
        chk(fe_sample, 1, "free run restart");
        rr(8'h30, 32'h1, "busy in free run");
        wait_n(8);
        wr(8'h00, 0);
        wait_n(3);
        chk(fe_sample, 0, "disable aborts");
        rr(8'h30, 32'h0, "idle after abort");
        $display("t_free done");
    endtask
    // soft reset clears everything except the debug register
    task t_soft_rst;
        logic [7:0] za[8];
        za = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h24};
        wr(8'h2C, 1);
        wr(8'h00, 1);
        foreach (za[i]) rr(za[i], 0, "soft reset value");
        rr(8'h2C, 1, "debug kept");
        wr(8'h18, 2);
        wait_n(6);
        chk(fe_sample, 0, "start refused");
        $display("t_soft_rst done");
    endtask
    task print_verdict;
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // cuts a hang well past the expected run
    initial begin
        #400000;
        error_cnt++;
        print_verdict;
    end
    initial begin
        wait_n(8);
        reset <= 1'b0;
        t_reset;
        t_protect;
        t_conv;
        t_ovr;
        t_ien;
        t_trig;
        t_free;
        t_soft_rst;
        print_verdict;
    end
endmodule // adc_conversion_control_tb
`default_nettype wire
